// ===== rtl/mode_reg_pkg.sv
package mode_reg_pkg;
  localparam int ADDR_W = 13;
  localparam int BA_W   = 2;
  localparam logic [1:0] BA_MR   = 2'h0;
  localparam logic [1:0] BA_EMR1 = 2'h1;
  localparam logic [1:0] BA_EMR2 = 2'h2;
  localparam logic [1:0] BA_EMR3 = 2'h3;
  // main register field positions
  localparam int MR_BL_LO  = 0;
  localparam int MR_BT     = 3;
  localparam int MR_CL_LO  = 4;
  localparam int MR_TM     = 7;
  localparam int MR_DLLRST = 8;
  localparam int MR_WR_LO  = 9;
  // extended one field positions
  localparam int E1_DLLDIS = 0;
  localparam int E1_HALF   = 1;
  localparam int E1_RTT0   = 2;
  localparam int E1_AL_LO  = 3;
  localparam int E1_RTT1   = 6;
  localparam int E1_OCD_LO = 7;
  localparam int E1_NDQS   = 10;
  localparam int E1_QOFF   = 12;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] AL_MAX_STD = 3'h4;
  localparam logic [2:0] AL_FIVE    = 3'h5;
  localparam logic [2:0] OCD_EXIT   = 3'h0;
  localparam logic [2:0] OCD_DRV1   = 3'h1;
  localparam logic [2:0] OCD_DRV0   = 3'h2;
  localparam logic [2:0] OCD_ADJ    = 3'h4;
  localparam logic [2:0] OCD_DFLT   = 3'h7;
  typedef enum {ocd_idle, ocd_drive1, ocd_drive0, ocd_adjust, ocd_default} ocd_mode_t;
endpackage : mode_reg_pkg

// ===== rtl/cmd_decode.sv
`timescale 1ns/100ps
module cmd_decode
  import mode_reg_pkg::*;
(
  // command pins, already synchronised
  input  wire logic            cs_n,
  input  wire logic            ras_n,
  input  wire logic            cas_n,
  input  wire logic            we_n,
  input  wire logic [BA_W-1:0] ba,
  // decoded strobes
  output logic                 wr_mr,
  output logic                 wr_emr1,
  output logic                 wr_emr2,
  output logic                 wr_emr3
);
  logic load;
  assign load    = !cs_n && !ras_n && !cas_n && !we_n;
  assign wr_mr   = load && (ba == BA_MR);
  assign wr_emr1 = load && (ba == BA_EMR1);
  assign wr_emr2 = load && (ba == BA_EMR2);
  assign wr_emr3 = load && (ba == BA_EMR3);
endmodule : cmd_decode

// ===== rtl/ocd_decode.sv
`timescale 1ns/100ps
module ocd_decode
  import mode_reg_pkg::*;
(
  input  wire logic [2:0] code,
  output ocd_mode_t       mode,
  output logic            undefined
);
  always_comb begin
    undefined = 1'b0;
    case (code)
      OCD_EXIT: mode = ocd_idle;
      OCD_DRV1: mode = ocd_drive1;
      OCD_DRV0: mode = ocd_drive0;
      OCD_ADJ:  mode = ocd_adjust;
      OCD_DFLT: mode = ocd_default;
      default: begin
        mode      = ocd_idle;
        undefined = 1'b1;
      end
    endcase
  end
endmodule : ocd_decode

// ===== rtl/mode_registers.sv
`timescale 1ns/100ps
module mode_registers
  import mode_reg_pkg::*;
#(
  parameter bit AL5_SUPPORTED = 1'b0
)(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // command and address pins
  input  wire logic              cke,
  input  wire logic              cs_n,
  input  wire logic              ras_n,
  input  wire logic              cas_n,
  input  wire logic              we_n,
  input  wire logic [BA_W-1:0]   ba,
  input  wire logic [ADDR_W-1:0] addr,
  // self refresh state from the command logic
  input  wire logic              self_refresh,
  // main register fields
  output logic [2:0]             burst_len,
  output logic                   burst_bl8,
  output logic                   burst_interleave,
  output logic [2:0]             cas_latency,
  output logic                   test_mode,
  output logic                   dll_reset_pulse,
  output logic [2:0]             write_recovery,
  // extended one fields
  output logic                   dll_enabled,
  output logic                   half_drive,
  output logic [1:0]             term_sel,
  output logic [2:0]             additive_latency,
  output logic                   al_code_bad,
  output logic [2:0]             ocd_code,
  output ocd_mode_t              ocd_mode,
  output logic                   ocd_code_bad,
  output logic                   dqs_n_disable,
  output logic                   outputs_off,
  // extended two and three raw contents
  output logic [ADDR_W-1:0]      emr2,
  output logic [ADDR_W-1:0]      emr3,
  // which registers have been written since reset
  output logic [3:0]             written
);
  // pins pass two flops before decode
  logic [4+BA_W+ADDR_W:0] sync1;
  logic [4+BA_W+ADDR_W:0] sync2;
  logic                   s_cke;
  logic                   s_cs_n;
  logic                   s_ras_n;
  logic                   s_cas_n;
  logic                   s_we_n;
  logic [BA_W-1:0]        s_ba;
  logic [ADDR_W-1:0]      s_addr;
  logic                   sr_q;
  logic                   wr_mr;
  logic                   wr_emr1;
  logic                   wr_emr2;
  logic                   wr_emr3;
  logic                   dll_dis_bit;
  logic [2:0]             al_code;
  logic                   ocd_bad_c;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '1;
      sync2 <= '1;
      sr_q  <= 1'b0;
    end else begin
      sync1 <= {cke, cs_n, ras_n, cas_n, we_n, ba, addr};
      sync2 <= sync1;
      sr_q  <= self_refresh;
    end
  end
  assign {s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_ba, s_addr} = sync2;

  cmd_decode u_dec (
    .cs_n    (s_cs_n || !s_cke),
    .ras_n   (s_ras_n),
    .cas_n   (s_cas_n),
    .we_n    (s_we_n),
    .ba      (s_ba),
    .wr_mr   (wr_mr),
    .wr_emr1 (wr_emr1),
    .wr_emr2 (wr_emr2),
    .wr_emr3 (wr_emr3)
  );

  // whole register replaced on each write; no array state lives here
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      burst_len        <= BL_4;
      burst_interleave <= 1'b0;
      cas_latency      <= 3'h0;
      test_mode        <= 1'b0;
      write_recovery   <= 3'h0;
    end else if (wr_mr) begin
      burst_len        <= s_addr[MR_BL_LO +: 3];
      burst_interleave <= s_addr[MR_BT];
      cas_latency      <= s_addr[MR_CL_LO +: 3];
      test_mode        <= s_addr[MR_TM];
      write_recovery   <= s_addr[MR_WR_LO +: 3];
    end
  end
  assign burst_bl8 = (burst_len == BL_8);

  // dll reset is a request, not held state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dll_reset_pulse <= 1'b0;
    end else begin
      dll_reset_pulse <= wr_mr && s_addr[MR_DLLRST];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dll_dis_bit      <= 1'b1;
      half_drive       <= 1'b0;
      term_sel         <= 2'h0;
      al_code          <= 3'h0;
      ocd_code         <= OCD_EXIT;
      dqs_n_disable    <= 1'b0;
      outputs_off      <= 1'b0;
    end else if (wr_emr1) begin
      dll_dis_bit      <= s_addr[E1_DLLDIS];
      half_drive       <= s_addr[E1_HALF];
      term_sel         <= {s_addr[E1_RTT1], s_addr[E1_RTT0]};
      al_code          <= s_addr[E1_AL_LO +: 3];
      ocd_code         <= s_addr[E1_OCD_LO +: 3];
      dqs_n_disable    <= s_addr[E1_NDQS];
      outputs_off      <= s_addr[E1_QOFF];
    end
  end

  // dll follows the register but is forced off while in self refresh
  assign dll_enabled = !dll_dis_bit && !sr_q;

  // reserved latency codes are flagged and clamp to zero
  always_comb begin
    al_code_bad      = 1'b0;
    additive_latency = al_code;
    if (al_code > AL_FIVE || (al_code == AL_FIVE && !AL5_SUPPORTED)) begin
      al_code_bad      = 1'b1;
      additive_latency = 3'h0;
    end
  end

  ocd_decode u_ocd (
    .code      (ocd_code),
    .mode      (ocd_mode),
    .undefined (ocd_bad_c)
  );
  assign ocd_code_bad = ocd_bad_c;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      emr2 <= '0;
      emr3 <= '0;
    end else begin
      if (wr_emr2) begin
        emr2 <= s_addr;
      end
      if (wr_emr3) begin
        emr3 <= s_addr;
      end
    end
  end

  // contents count as undefined until each register is written once
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      written <= 4'h0;
    end else begin
      written <= written | {wr_emr3, wr_emr2, wr_emr1, wr_mr};
    end
  end
endmodule : mode_registers

// ===== tb/mode_registers_checker.sv
`timescale 1ns/100ps
module mode_registers_checker
  import mode_reg_pkg::*;
#(parameter bit AL5_SUPPORTED = 1'b0)(
  // pins
  input wire logic              clk_sys, nrst, cke, cs_n, ras_n, cas_n, we_n, self_refresh,
  input wire logic [BA_W-1:0]   ba,
  input wire logic [ADDR_W-1:0] addr, emr2,
  // fields
  input wire logic [2:0]        burst_len, cas_latency,
  input wire logic              dll_reset_pulse, dll_enabled, outputs_off, ocd_code_bad,
  input wire logic              al_code_bad,
  input wire logic [3:0]        written
);
  wire cmd = cke && !cs_n && !ras_n && !cas_n && !we_n;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_mr_fields: assert property (cmd && ba == BA_MR |-> ##3
    burst_len == $past(addr[2:0], 3) && cas_latency == $past(addr[6:4], 3))
    else $error("mode fields wrong");
  a_dll_pulse: assert property (
    dll_reset_pulse |-> $past(cmd && ba == BA_MR && addr[MR_DLLRST], 3))
    else $error("stray dll reset");
  a_mr_only: assert property ($changed(burst_len) |-> $past(cmd && ba == BA_MR, 3))
    else $error("burst length changed without write");
  a_e1_qoff: assert property (cmd && ba == BA_EMR1 |-> ##3
    outputs_off == $past(addr[E1_QOFF], 3) && written[1]) else $error("output disable wrong");
  a_al_code: assert property (cmd && ba == BA_EMR1 |-> ##3
    al_code_bad == ($past(addr[5:3], 3) > (AL5_SUPPORTED ? 3'h5 : 3'h4)))
    else $error("latency code flag wrong");
  a_ocd_code: assert property (cmd && ba == BA_EMR1 |-> ##3
    ocd_code_bad == ($past(addr[9:7], 3) inside {3'h3, 3'h5, 3'h6}))
    else $error("calibration code flag wrong");
  a_e2_raw: assert property (cmd && ba == BA_EMR2 |-> ##3 emr2 == $past(addr, 3))
    else $error("ext2 contents wrong");
  a_self_ref: assert property (self_refresh |=> !dll_enabled)
    else $error("dll on in self refresh");
  c_dll_rst: cover property (cmd && ba == BA_MR && addr[MR_DLLRST]);
  c_al_bad: cover property (al_code_bad);
  c_sr_exit: cover property ($fell(self_refresh));
endmodule : mode_registers_checker

bind mode_registers mode_registers_checker #(.AL5_SUPPORTED(AL5_SUPPORTED)) u_checker (
  .clk_sys, .nrst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .self_refresh, .ba, .addr, .emr2,
  .burst_len, .cas_latency, .dll_reset_pulse, .dll_enabled, .outputs_off, .ocd_code_bad,
  .al_code_bad, .written);

// ===== tb/ctrl_model.sv
`timescale 1ns/100ps
module ctrl_model
  import mode_reg_pkg::*;
#(parameter int TMRD = 2)(
  input  wire logic         clk_sys,
  output logic              cke, cs_n, ras_n, cas_n, we_n,
  output logic [BA_W-1:0]   ba,
  output logic [ADDR_W-1:0] addr
);
  initial begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = '0;
    addr = '0;
  end
  // cke_v low only where a test wants the command ignored
  task automatic issue(input logic [1:0] sel, input logic [12:0] a, input logic cke_v);
    @(negedge clk_sys);
    cke = cke_v;
    {cs_n, ras_n, cas_n, we_n} = 4'h0;
    ba = sel;
    addr = a;
    @(negedge clk_sys);
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    // deselected pins never keep the last value
    ba = ~sel;
    addr = ~a;
    repeat (TMRD) @(negedge clk_sys);
  endtask : issue
endmodule : ctrl_model

// ===== tb/test_mode_registers.sv
`timescale 1ns/100ps
module test_mode_registers
  import mode_reg_pkg::*;
;
  typedef struct {int due; int kind; logic [15:0] exp;} note_t;
  note_t             q[$];
  logic              clk_sys = 1'b0, nrst = 1'b0, self_refresh = 1'b0;
  logic              cke, cs_n, ras_n, cas_n, we_n, burst_bl8, burst_interleave, test_mode;
  logic              dll_reset_pulse, dll_enabled, half_drive, al_code_bad, ocd_code_bad;
  logic              dqs_n_disable, outputs_off;
  logic [BA_W-1:0]   ba;
  logic [1:0]        term_sel;
  logic [ADDR_W-1:0] addr, emr2, emr3, last [4];
  logic [2:0]        burst_len, cas_latency, write_recovery, additive_latency, ocd_code;
  logic [3:0]        written;
  ocd_mode_t         ocd_mode;
  int                cyc = 0, num_errors = 0, tests_run = 0;
  always #50 clk_sys = ~clk_sys;
  ctrl_model u_ctrl_model (.clk_sys, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);
  mode_registers u_mode_registers (.clk_sys, .nrst, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
    .addr, .self_refresh, .burst_len, .burst_bl8, .burst_interleave, .cas_latency, .test_mode,
    .dll_reset_pulse, .write_recovery, .dll_enabled, .half_drive, .term_sel, .additive_latency,
    .al_code_bad, .ocd_code, .ocd_mode, .ocd_code_bad, .dqs_n_disable, .outputs_off, .emr2,
    .emr3, .written);
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic put(input int kind, input logic [12:0] a);
    logic [15:0] e;
    ocd_mode_t   m;
    // calibration mode expected from the code table, undefined codes idle
    case (a[9:7])
      OCD_DRV1: m = ocd_drive1;
      OCD_DRV0: m = ocd_drive0;
      OCD_ADJ:  m = ocd_adjust;
      OCD_DFLT: m = ocd_default;
      default:  m = ocd_idle;
    endcase
    case (kind)
      0: e = {3'h0, a[2:0] == 3'h3, a[8], a[11:9], a[7], a[6:4], a[3], a[2:0]};
      1: e = {a[12], a[10], a[9:7], a[6], a[2], a[1], !a[0], (a[5:3] > 3'h4) ? 3'h0 : a[5:3],
              a[5:3] > 3'h4, a[9:7] inside {3'h3, 3'h5, 3'h6}, 2'h0};
      2, 3: e = {3'h0, a};
      default: e = {15'h0, a[0]};
    endcase
    q.push_back('{cyc + (kind == 4 ? 1 : 4), kind, e});
    if (kind == 0) q.push_back('{cyc + 5, 5, 16'h0});
    if (kind == 1) q.push_back('{cyc + 4, 6, 16'(m)});
  endtask : put
  task automatic wr(input logic [1:0] sel, input logic [12:0] a, input logic c = 1'b1);
    put(sel, c ? a : last[sel]);
    if (c) last[sel] = a;
    u_ctrl_model.issue(sel, a, c);
  endtask : wr
  always @(negedge clk_sys) begin
    while (q.size() > 0 && q[0].due == cyc) begin
      case (q[0].kind)
        0: check("mode", {3'h0, burst_bl8, dll_reset_pulse, write_recovery, test_mode, cas_latency, burst_interleave, burst_len}, q[0].exp);
        1: check("ext1", {outputs_off, dqs_n_disable, ocd_code, term_sel, half_drive, dll_enabled, additive_latency, al_code_bad, ocd_code_bad, 2'h0}, q[0].exp);
        2: check("ext2", {3'h0, emr2}, q[0].exp);
        3: check("ext3", {3'h0, emr3}, q[0].exp);
        6: check("ocd mode", 16'(ocd_mode), q[0].exp);
        default: check("dll", {15'h0, q[0].kind == 5 ? dll_reset_pulse : dll_enabled}, q[0].exp);
      endcase
      void'(q.pop_front());
    end
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h584aafbc));
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    wr(2, 13'($urandom) & 13'h0087);
    wr(3, 13'h0000);
    wr(1, 13'h0380);
    wr(1, 13'h0000);
    wr(0, 13'h0132);
    repeat (200) @(negedge clk_sys);
    $display("init done");
    // no bank is ever opened, so every rewrite sees all banks precharged
    for (int i = 0; i < 24; i++) wr(2'(i), 13'($urandom));
    $display("random writes done");
    // every latency and calibration code, reserved ones included
    for (int k = 0; k < 8; k++) wr(1, {3'h0, 3'(k), 1'b0, 3'(k), 3'h0});
    wr(1, 13'h0000);
    $display("code sweep done");
    self_refresh = 1'b1;
    put(4, 13'h0);
    @(negedge clk_sys);
    self_refresh = 1'b0;
    put(4, 13'h1);
    repeat (2) @(negedge clk_sys);
    $display("self refresh done");
    wr(2, 13'h1555, 1'b0);
    repeat (6) @(negedge clk_sys);
    check("written", {12'h0, written}, 16'h000f);
    $display("ignored write done");
    final_report();
  end
endmodule : test_mode_registers
